// ==== kms_top.sv ====
// Key matrix scanner with serial key read link and AXI4-Lite control registers.
`include "kms_params.svh"
`timescale 1ns/1ns
module kms_top
  import kms_pkg::*;
#(
  parameter int TBASE_DIV = `KMS_TBASE_DIV
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic time_base_pin,
  input wire logic [4:0] return_lines,
  output logic [5:0] scan_rows,
  input wire logic serial_shift_clock,
  input wire logic chip_enable,
  input wire logic serial_data_in,
  output logic req_data_out,
  output logic req_data_oe_n,
  output logic display_off,
  output logic time_base_run,
  output logic clk_out_allow
);

  // --------------------------------------------------------------------------
  // Synchronised pins.
  // --------------------------------------------------------------------------
  logic [8:0] pins_s;
  logic ext_clk_s;
  logic shift_clk_s;
  logic ce_s;
  logic di_s;
  logic [4:0] ret_s;
  logic ext_clk_d_r;
  logic shift_clk_d_r;
  logic ce_d_r;

  kms_sync #(.WIDTH(9)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({time_base_pin, serial_shift_clock, chip_enable, serial_data_in, return_lines}),
    .sync_out(pins_s)
  );

  assign ext_clk_s = pins_s[8];
  assign shift_clk_s = pins_s[7];
  assign ce_s = pins_s[6];
  assign di_s = pins_s[5];
  assign ret_s = pins_s[4:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_clk_d_r <= 1'b0;
      shift_clk_d_r <= 1'b0;
      ce_d_r <= 1'b0;
    end
    else
    begin
      ext_clk_d_r <= ext_clk_s;
      shift_clk_d_r <= shift_clk_s;
      ce_d_r <= ce_s;
    end
  end

  // --------------------------------------------------------------------------
  // Control decode.
  // --------------------------------------------------------------------------
  logic [`KMS_CTL_WIDTH-1:0] ctrl_r;
  logic sleep_ctl_a;
  logic sleep_ctl_b;
  logic clock_source_select;
  logic scan_disable_bit;
  logic row_select_a;
  logic row_select_b;
  logic sleep_mode;
  logic [5:0] usable_rows;
  logic [5:0] idle_rows;
  kms_keys_t key_mask;

  assign sleep_ctl_a = ctrl_r[`KMS_CTL_SLEEP_A];
  assign sleep_ctl_b = ctrl_r[`KMS_CTL_SLEEP_B];
  assign clock_source_select = ctrl_r[`KMS_CTL_CLK_SEL];
  assign scan_disable_bit = ctrl_r[`KMS_CTL_SCAN_DIS];
  assign row_select_a = ctrl_r[`KMS_CTL_ROW_SEL_A];
  assign row_select_b = ctrl_r[`KMS_CTL_ROW_SEL_B];
  assign sleep_mode = sleep_ctl_a | sleep_ctl_b;
  assign usable_rows = {4'hf, ~row_select_b, ~row_select_a};
  assign key_mask = {20'hfffff, {5{~row_select_b}}, {5{~row_select_a}}};
  // In sleep only the first bit keeps rows zero to four high.
  assign idle_rows = (!sleep_mode) ? 6'h3f : {1'b1, {5{sleep_ctl_a}}};

  // --------------------------------------------------------------------------
  // Time base.
  // --------------------------------------------------------------------------
  kms_state_e state_r;
  logic [$clog2(TBASE_DIV)-1:0] div_r;
  logic div_wrap;
  logic ext_rise;
  logic tb_run;
  logic tick;

  assign div_wrap = (div_r == ($clog2(TBASE_DIV))'(TBASE_DIV - 1));
  assign ext_rise = ext_clk_s & ~ext_clk_d_r;
  // A sleeping device keeps its time base only while a scan or request is live.
  assign tb_run = !sleep_mode || (state_r != KMS_IDLE);
  assign tick = tb_run && (clock_source_select ? ext_rise : div_wrap);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tb_run || clock_source_select)
      div_r <= '0;
    else if (div_wrap)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // --------------------------------------------------------------------------
  // Scanner.
  // --------------------------------------------------------------------------
  logic [9:0] tcnt_r;
  logic [5:0] slot_r;
  logic [2:0] row_r;
  logic pass_r;
  kms_keys_t cur_r;
  kms_keys_t first_r;
  kms_keys_t keys_r;
  logic sleep_ack_r;
  logic read_done;
  logic press;
  logic slot_end;
  logic pass_end;
  logic req_time;
  logic agree;
  kms_keys_t sampled;

  assign press = |ret_s;
  assign slot_end = tick && (slot_r == 6'(`KMS_ROW_SLOT_T - 1));
  assign pass_end = slot_end && (row_r == 3'(`KMS_ROWS - 1));
  assign req_time = tick && (tcnt_r == 10'(`KMS_REQ_DELAY_T - 1));
  assign agree = (cur_r == first_r);
  assign sampled = cur_r & key_mask;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= KMS_IDLE;
      tcnt_r <= '0;
      slot_r <= '0;
      row_r <= '0;
      pass_r <= 1'b0;
      cur_r <= '0;
      first_r <= '0;
      keys_r <= '0;
      sleep_ack_r <= 1'b0;
    end
    else if (scan_disable_bit)
    begin
      state_r <= KMS_IDLE;
      tcnt_r <= '0;
      slot_r <= '0;
      row_r <= '0;
      pass_r <= 1'b0;
      if (state_r == KMS_PEND)
        keys_r <= '0;
    end
    else
    begin
      case (state_r)
        KMS_IDLE:
        begin
          tcnt_r <= '0;
          slot_r <= '0;
          row_r <= '0;
          pass_r <= 1'b0;
          if (press)
            state_r <= KMS_SCAN;
        end
        KMS_SCAN:
        begin
          if (tick)
          begin
            tcnt_r <= tcnt_r + 1'b1;
            slot_r <= slot_end ? 6'h00 : slot_r + 1'b1;
          end
          if (slot_end)
          begin
            // Key bit index is row times five plus column.
            cur_r[row_r*`KMS_COLS +: `KMS_COLS] <= ret_s;
            row_r <= (row_r == 3'(`KMS_ROWS - 1)) ? 3'h0 : row_r + 1'b1;
          end
          if (pass_end)
          begin
            pass_r <= ~pass_r;
            if (!pass_r)
              first_r <= {ret_s, cur_r[24:0]};
            else
              state_r <= KMS_WAIT;
          end
        end
        KMS_WAIT:
        begin
          if (tick)
            tcnt_r <= tcnt_r + 1'b1;
          if (req_time)
          begin
            tcnt_r <= '0;
            pass_r <= 1'b0;
            if (agree && (|sampled))
            begin
              keys_r <= sampled;
              sleep_ack_r <= sleep_mode;
              state_r <= KMS_PEND;
            end
            else if (press || (|cur_r))
              state_r <= KMS_SCAN;
            else
              state_r <= KMS_IDLE;
          end
        end
        KMS_PEND:
        begin
          sleep_ack_r <= sleep_mode;
          if (read_done)
            state_r <= KMS_SCAN;
        end
        default:
          state_r <= KMS_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Serial key read link.
  // --------------------------------------------------------------------------
  logic [7:0] addr_sr_r;
  logic [30:0] out_sr_r;
  logic rd_active_r;
  logic shift_rise;
  logic shift_fall;
  logic ce_rise;
  logic ce_fall;
  logic pending;

  assign shift_rise = shift_clk_s & ~shift_clk_d_r;
  assign shift_fall = ~shift_clk_s & shift_clk_d_r;
  assign ce_rise = ce_s & ~ce_d_r;
  assign ce_fall = ~ce_s & ce_d_r;
  assign read_done = ce_fall & rd_active_r;
  assign pending = (state_r == KMS_PEND);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_sr_r <= '0;
      out_sr_r <= '0;
      rd_active_r <= 1'b0;
    end
    else
    begin
      if (shift_rise && !ce_s)
        addr_sr_r <= {di_s, addr_sr_r[7:1]};
      if (ce_rise)
      begin
        rd_active_r <= (addr_sr_r == `KMS_READ_ADDR);
        out_sr_r <= {sleep_ack_r, keys_r};
      end
      else if (ce_fall)
        rd_active_r <= 1'b0;
      else if (shift_fall && ce_s && rd_active_r)
        out_sr_r <= {1'b0, out_sr_r[30:1]};
    end
  end

  // --------------------------------------------------------------------------
  // Pin outputs.
  // --------------------------------------------------------------------------
  logic [5:0] scan_drive;
  logic pull_low;

  assign scan_drive = (state_r == KMS_SCAN) ? (6'h01 << row_r) : idle_rows;
  // The request line is never driven high; the pull-up makes the high level.
  assign pull_low = ce_s ? (rd_active_r & ~out_sr_r[0]) : pending;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scan_rows <= '0;
      req_data_out <= 1'b0;
      req_data_oe_n <= 1'b1;
      display_off <= 1'b1;
      time_base_run <= 1'b0;
      clk_out_allow <= 1'b0;
    end
    else
    begin
      scan_rows <= scan_drive & usable_rows;
      req_data_out <= 1'b0;
      req_data_oe_n <= ~pull_low;
      display_off <= sleep_mode;
      time_base_run <= tb_run;
      clk_out_allow <= ~sleep_mode;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave.
  // --------------------------------------------------------------------------
  logic [3:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic w_have_r;
  logic w_strb_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic wr_ctrl;
  logic rd_hit;
  logic [31:0] rd_mux;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_ctrl = wr_go && (aw_addr_r == `KMS_OFS_CTRL);
  assign rd_hit = (s_axi_araddr == `KMS_OFS_CTRL) || (s_axi_araddr == `KMS_OFS_STATUS)
    || (s_axi_araddr == `KMS_OFS_KEYS);
  assign rd_mux = (s_axi_araddr == `KMS_OFS_CTRL) ? {26'h0, ctrl_r}
    : (s_axi_araddr == `KMS_OFS_STATUS) ? {29'h0, state_r != KMS_IDLE, sleep_mode, pending}
    : (s_axi_araddr == `KMS_OFS_KEYS) ? {1'b0, sleep_ack_r, keys_r}
    : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `KMS_CTL_RESET;
      aw_addr_r <= '0;
      aw_have_r <= 1'b0;
      w_data_r <= '0;
      w_have_r <= 1'b0;
      w_strb_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_have_r && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (w_take)
      begin
        w_data_r <= s_axi_wdata;
        w_have_r <= 1'b1;
        w_strb_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      else if (!w_have_r && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == `KMS_OFS_CTRL || aw_addr_r == `KMS_OFS_STATUS
          || aw_addr_r == `KMS_OFS_KEYS) ? 2'b00 : 2'b10;
        if (wr_ctrl && w_strb_r)
          ctrl_r <= w_data_r[`KMS_CTL_WIDTH-1:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule // kms_top

// ==== kms_params.svh ====
// Constants for the key matrix scanner: offsets, fields, reset values, timing counts.
`ifndef KMS_PARAMS_SVH
`define KMS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define KMS_OFS_CTRL 4'h0
`define KMS_OFS_STATUS 4'h4
`define KMS_OFS_KEYS 4'h8

// ----------------------------------------------------------------------------
// Control register fields and reset value.
// ----------------------------------------------------------------------------
`define KMS_CTL_SLEEP_A 0
`define KMS_CTL_SLEEP_B 1
`define KMS_CTL_CLK_SEL 2
`define KMS_CTL_SCAN_DIS 3
`define KMS_CTL_ROW_SEL_A 4
`define KMS_CTL_ROW_SEL_B 5
`define KMS_CTL_WIDTH 6
`define KMS_CTL_RESET 6'h00

// ----------------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------------
`define KMS_STS_PENDING 0
`define KMS_STS_SLEEP 1
`define KMS_STS_BUSY 2

// ----------------------------------------------------------------------------
// Matrix shape, serial read address and timing in time-base periods.
// ----------------------------------------------------------------------------
`define KMS_ROWS 6
`define KMS_COLS 5
`define KMS_KEYS 30
`define KMS_READ_ADDR 8'h43
`define KMS_SCAN_PERIOD_T 288
`define KMS_REQ_DELAY_T 615
`define KMS_ROW_SLOT_T (`KMS_SCAN_PERIOD_T / `KMS_ROWS)
`define KMS_TBASE_DIV 8

`endif

// ==== kms_pkg.sv ====
// Types shared by the key matrix scanner files.
package kms_pkg;

  typedef enum logic [1:0]
  {
    KMS_IDLE = 2'b00,
    KMS_SCAN = 2'b01,
    KMS_WAIT = 2'b10,
    KMS_PEND = 2'b11
  } kms_state_e;

  typedef logic [29:0] kms_keys_t;

endpackage

// ==== kms_sync.sv ====
// Two-flop synchroniser for a group of inputs from outside the clock domain.
`timescale 1ns/1ns
module kms_sync
  import kms_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // The first stage feeds the second stage only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // kms_sync

// ==== kms_top_chk.sv ====
// Port-level assertions for the key matrix scanner.
`timescale 1ns/1ns
module kms_top_chk
  import kms_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [5:0] scan_rows,
  input wire logic req_data_out,
  input wire logic req_data_oe_n,
  input wire logic display_off,
  input wire logic time_base_run,
  input wire logic clk_out_allow
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pull_low_only: assert property (req_data_out == 1'b0)
    else $error("request line driven high");
  a_sleep_no_clk: assert property (display_off |-> !clk_out_allow)
    else $error("clock output allowed while asleep");
  a_row_shape: assert property ($onehot0(scan_rows) || (&scan_rows[5:2]))
    else $error("illegal scan row pattern");
  a_reset_clear: assert property (
    $rose(aresetn) |-> scan_rows == 6'h00 && req_data_oe_n && !time_base_run)
    else $error("reset did not clear scanner");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  a_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc |=> s_axi_rvalid && s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  c_request: cover property ($fell(req_data_oe_n));
  c_sleep: cover property ($rose(display_off));
  c_refuse: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // kms_top_chk

bind kms_top kms_top_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
  .s_axi_rvalid, .scan_rows, .req_data_out, .req_data_oe_n, .display_off, .time_base_run,
  .clk_out_allow);

// ==== kms_ctl_model.sv ====
// Behavioural system controller over the four-wire serial key read link.
`include "kms_params.svh"
`timescale 1ns/1ns
module kms_ctl_model
(
  input wire logic req_data_out,
  input wire logic req_data_oe_n,
  output logic serial_shift_clock,
  output logic chip_enable,
  output logic serial_data_in
);
  logic do_line;
  // The pull-up gives the high level whenever the device lets go.
  assign do_line = req_data_oe_n ? 1'b1 : req_data_out;
  initial
  begin
    serial_shift_clock = 1'b0;
    chip_enable = 1'b0;
    serial_data_in = 1'b0;
  end
  // A read starts only while the request line is low, and off the clock edge.
  task automatic read_keys(output logic [30:0] bits);
    logic [7:0] adr;
    wait (do_line === 1'b0);
    #1;
    adr = `KMS_READ_ADDR;
    for (int i = 0; i < 8; i++)
    begin
      serial_data_in = adr[i];
      #32 serial_shift_clock = 1'b1;
      #32 serial_shift_clock = 1'b0;
    end
    #32 chip_enable = 1'b1;
    for (int i = 0; i < 31; i++)
    begin
      #32 bits[i] = do_line;
      serial_data_in = ~serial_data_in;
      serial_shift_clock = 1'b1;
      #32 serial_shift_clock = 1'b0;
    end
    #32 chip_enable = 1'b0;
    #64;
  endtask
endmodule // kms_ctl_model

// ==== test_key_matrix_scanner.sv ====
// Self-checking bench for the key matrix scanner.
`include "kms_params.svh"
`timescale 1ns/1ns
module test_key_matrix_scanner
  import kms_pkg::*;
();
  localparam int TB_DIV = 2;
  // Key press to request: 615 time-base periods of TB_DIV clocks each.
  localparam int REQ_CYC = 615 * TB_DIV;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic time_base_pin, serial_shift_clock, chip_enable, serial_data_in;
  logic [4:0] return_lines, rl;
  logic [5:0] scan_rows;
  logic req_data_out, req_data_oe_n, display_off, time_base_run, clk_out_allow;
  kms_keys_t keys;
  int n_fail, n_tests;
  logic [31:0] d;
  logic [1:0] r;
  kms_top #(.TBASE_DIV(TB_DIV)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .time_base_pin, .return_lines, .scan_rows,
    .serial_shift_clock, .chip_enable, .serial_data_in, .req_data_out, .req_data_oe_n,
    .display_off, .time_base_run, .clk_out_allow);
  kms_ctl_model ctl (.req_data_out, .req_data_oe_n, .serial_shift_clock, .chip_enable,
    .serial_data_in);
  // ----------------------------------------------------------------
  // Key matrix: a return line is high when a pressed key sits in a driven row.
  // ----------------------------------------------------------------
  always_comb
  begin
    rl = 5'h00;
    for (int i = 0; i < 6; i++)
      if (scan_rows[i])
        rl = rl | keys[5*i +: 5];
  end
  always @(posedge aclk)
  begin
    return_lines <= rl;
    time_base_pin <= ~time_base_pin;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Keys are released once the request shows, so the read sees the held buffer.
  task automatic press_wait(input kms_keys_t k);
    int n;
    n = 0;
    @(posedge aclk);
    keys <= k;
    while (req_data_oe_n !== 1'b0 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, n >= REQ_CYC && n < REQ_CYC + 40}, 32'h1);
    keys <= '0;
  endtask
  task automatic quiet(input kms_keys_t k);
    int lows;
    lows = 0;
    @(posedge aclk);
    keys <= k;
    repeat (REQ_CYC + 300)
    begin
      @(posedge aclk);
      lows += (req_data_oe_n !== 1'b1);
    end
    keys <= '0;
    chk(lows, 0);
  endtask
  task automatic read_chk(input kms_keys_t k, input logic ack);
    logic [30:0] b;
    ctl.read_keys(b);
    chk({1'b0, b}, {1'b0, ack, k});
    chk({31'h0, $countones(b[29:0]) > 2}, {31'h0, $countones(k) > 2});
    repeat (20) @(posedge aclk);
    chk({31'h0, req_data_oe_n}, 32'h1);
    axi_rd(`KMS_OFS_STATUS, d, r);
    chk(d & 32'h4, 32'h4);
    // The rescan with all keys up must run out before the next press is timed.
    repeat (REQ_CYC + 40) @(posedge aclk);
    axi_rd(`KMS_OFS_STATUS, d, r);
    chk(d & 32'h5, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({26'h0, scan_rows}, 32'h3f);
    chk({31'h0, req_data_oe_n}, 32'h1);
    axi_rd(`KMS_OFS_KEYS, d, r);
    chk(d, 32'h0);
    axi_rd(4'hc, d, r);
    chk({30'h0, r}, 32'h2);
    $display("t_reset done");
  endtask
  task automatic t_keys;
    press_wait(30'h2000_0801);
    read_chk(30'h2000_0801, 1'b0);
    axi_wr(`KMS_OFS_CTRL, 32'h30);
    press_wait(30'h0010_0081);
    read_chk(30'h0010_0000, 1'b0);
    axi_wr(`KMS_OFS_CTRL, 32'h0);
    $display("t_keys done");
  endtask
  task automatic t_sleep;
    axi_wr(`KMS_OFS_CTRL, 32'h1);
    repeat (4) @(posedge aclk);
    chk({31'h0, display_off}, 32'h1);
    axi_wr(`KMS_OFS_CTRL, 32'h2);
    repeat (4) @(posedge aclk);
    chk({30'h0, display_off, clk_out_allow}, 32'h2);
    chk({26'h0, scan_rows}, 32'h20);
    chk({31'h0, time_base_run}, 32'h0);
    quiet(30'h0000_0002);
    press_wait(30'h0200_0000);
    read_chk(30'h0200_0000, 1'b1);
    chk({31'h0, display_off}, 32'h1);
    press_wait(30'h0200_0000);
    axi_wr(`KMS_OFS_CTRL, 32'h0);
    read_chk(30'h0200_0000, 1'b0);
    chk({31'h0, display_off}, 32'h0);
    $display("t_sleep done");
  endtask
  task automatic t_disable;
    press_wait(30'h0000_0008);
    axi_wr(`KMS_OFS_CTRL, 32'h8);
    repeat (4) @(posedge aclk);
    chk({31'h0, req_data_oe_n}, 32'h1);
    axi_rd(`KMS_OFS_KEYS, d, r);
    chk(d, 32'h0);
    quiet(30'h0000_0008);
    axi_wr(`KMS_OFS_CTRL, 32'h0);
    press_wait(30'h0000_0008);
    read_chk(30'h0000_0008, 1'b0);
    $display("t_disable done");
  endtask
  task automatic t_extclk;
    axi_wr(`KMS_OFS_CTRL, 32'h4);
    press_wait(30'h0000_0400);
    read_chk(30'h0000_0400, 1'b0);
    axi_wr(`KMS_OFS_CTRL, 32'h0);
    $display("t_extclk done");
  endtask
  task automatic close_out;
    $display("Counts: %0d compared, %0d mismatched", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, time_base_pin} = '0;
    s_axi_wstrb = 4'hf;
    keys = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset;
    t_keys;
    t_sleep;
    t_disable;
    t_extclk;
    close_out;
  end
  // The tests need roughly 24000 clocks; 50000 leaves ample margin.
  initial
  begin
    #200000;
    n_fail++;
    close_out;
  end
endmodule // test_key_matrix_scanner
